// [design/tve_std_subcarrier.sv]
// Control bus slave, standard, burst and subcarrier registers of the encoder
module tve_std_subcarrier #(
  parameter logic [6:0] DEV_ADDR = 7'h2a // Arbitrary bus address
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic scl_in,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe,
  input wire logic pixel_en,
  input wire logic rtc_fsc_valid,
  input wire logic [tve_pkg::FSC_W-1:0] rtc_fsc,
  output logic core_sleep,
  output logic dac_power_down,
  output logic luma_gain_select,
  output logic [tve_pkg::IRE_W-1:0] luma_span_tenth_ire,
  output logic [tve_pkg::SETUP_W-1:0] black_setup_tenth_ire,
  output logic chroma_bandwidth_select,
  output logic pal_mode,
  output logic line_length_select,
  output logic realtime_subcarrier_enable,
  output logic [tve_pkg::BURST_W-1:0] burst_amplitude,
  output logic [tve_pkg::FSC_W-1:0] subcarrier_freq_word,
  output logic [tve_pkg::PHASE_W-1:0] subcarrier_phase,
  output logic pal_switch,
  output logic line_start
);
  import tve_pkg::*;

  tve_bus_state_t state_reg, state_next;
  logic [3:0] cnt_reg, cnt_next;
  logic [7:0] shift_reg, shift_next;
  logic [7:0] sub_reg, sub_next;
  logic [7:0] tx_reg, tx_next;
  logic rw_reg, rw_next;
  logic drive_reg, drive_next;
  logic scl_q, sda_q;
  logic scl_rise, scl_fall, bus_start, bus_stop;
  logic wr_en, addr_hit;
  logic [7:0] rd_data;

  logic [7:0] std_reg, std_next;
  logic [7:0] burst_reg, burst_next;
  logic [FSC_W-1:0] fsc_reg, fsc_next;
  logic [FSC_W-1:0] rtc_reg, rtc_next;
  logic [IRE_W-1:0] span_reg, span_next;
  logic [SETUP_W-1:0] setup_reg, setup_next;

  // Previous line levels for edge and start/stop detection
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      scl_q <= 1'b1;
      sda_q <= 1'b1;
    end else begin
      scl_q <= scl_in;
      sda_q <= sda_in;
    end
  end

  assign scl_rise = scl_in & ~scl_q;
  assign scl_fall = ~scl_in & scl_q;
  assign bus_start = scl_in & scl_q & sda_q & ~sda_in;
  assign bus_stop = scl_in & scl_q & ~sda_q & sda_in;

  // Bus slave: address, subaddress, then auto-incrementing data bytes
  always_comb begin
    state_next = state_reg;
    cnt_next = cnt_reg;
    shift_next = shift_reg;
    sub_next = sub_reg;
    tx_next = tx_reg;
    rw_next = rw_reg;
    drive_next = drive_reg;
    wr_en = 1'b0;
    addr_hit = 1'b0;
    if (bus_start) begin
      state_next = ST_ADDR;
      cnt_next = 4'h0;
      drive_next = 1'b0;
    end else if (bus_stop) begin
      state_next = ST_IDLE;
      drive_next = 1'b0;
    end else if (scl_rise) begin
      if (state_reg inside {ST_ADDR, ST_SUB, ST_WR}) begin
        shift_next = {shift_reg[6:0], sda_in};
        cnt_next = cnt_reg + 4'h1;
      end else if (state_reg == ST_RD) begin
        cnt_next = cnt_reg + 4'h1;
      end else if (state_reg == ST_ACK_RD && sda_in) begin
        // Master refused the byte: read ends here
        state_next = ST_IDLE;
      end
    end else if (scl_fall) begin
      unique case (state_reg)
        ST_IDLE: begin
        end
        ST_ADDR: begin
          if (cnt_reg == BYTE_BITS) begin
            if (shift_reg[7:1] == DEV_ADDR) begin
              addr_hit = 1'b1;
              drive_next = 1'b1;
              rw_next = shift_reg[0];
              state_next = ST_ACK_ADDR;
            end else begin
              state_next = ST_IDLE;
            end
          end
        end
        ST_ACK_ADDR: begin
          cnt_next = 4'h0;
          if (rw_reg) begin
            tx_next = rd_data;
            drive_next = ~rd_data[7];
            state_next = ST_RD;
          end else begin
            drive_next = 1'b0;
            state_next = ST_SUB;
          end
        end
        ST_SUB: begin
          if (cnt_reg == BYTE_BITS) begin
            sub_next = shift_reg;
            drive_next = 1'b1;
            state_next = ST_ACK_SUB;
          end
        end
        ST_ACK_SUB: begin
          drive_next = 1'b0;
          cnt_next = 4'h0;
          state_next = ST_WR;
        end
        ST_WR: begin
          if (cnt_reg == BYTE_BITS) begin
            wr_en = 1'b1;
            drive_next = 1'b1;
            state_next = ST_ACK_WR;
          end
        end
        ST_ACK_WR: begin
          drive_next = 1'b0;
          cnt_next = 4'h0;
          sub_next = sub_reg + 8'h01;
          state_next = ST_WR;
        end
        ST_RD: begin
          if (cnt_reg == BYTE_BITS) begin
            drive_next = 1'b0;
            sub_next = sub_reg + 8'h01;
            state_next = ST_ACK_RD;
          end else begin
            drive_next = ~tx_reg[3'd7 - cnt_reg[2:0]];
          end
        end
        ST_ACK_RD: begin
          tx_next = rd_data;
          drive_next = ~rd_data[7];
          cnt_next = 4'h0;
          state_next = ST_RD;
        end
      endcase
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      state_reg <= ST_IDLE;
      cnt_reg <= 4'h0;
      shift_reg <= 8'h00;
      sub_reg <= 8'h00;
      tx_reg <= 8'h00;
      rw_reg <= 1'b0;
      drive_reg <= 1'b0;
    end else begin
      state_reg <= state_next;
      cnt_reg <= cnt_next;
      shift_reg <= shift_next;
      sub_reg <= sub_next;
      tx_reg <= tx_next;
      rw_reg <= rw_next;
      drive_reg <= drive_next;
    end
  end

  assign sda_out = 1'b0;
  assign sda_oe = drive_reg;

  // Unmapped subaddresses read as zero
  always_comb begin
    unique case (sub_reg)
      REG_STD_CTRL: rd_data = std_reg;
      REG_BURST: rd_data = burst_reg;
      REG_FSC_B0: rd_data = fsc_reg[7:0];
      REG_FSC_B1: rd_data = fsc_reg[15:8];
      REG_FSC_B2: rd_data = fsc_reg[23:16];
      REG_FSC_B3: rd_data = fsc_reg[31:24];
      default: rd_data = 8'h00;
    endcase
  end

  // Register bank
  always_comb begin
    std_next = std_reg;
    burst_next = burst_reg;
    fsc_next = fsc_reg;
    rtc_next = rtc_reg;
    if (wr_en) begin
      unique case (sub_reg)
        // Bit 3 is stored as written; software keeps it at zero
        REG_STD_CTRL: std_next = shift_reg;
        REG_BURST: burst_next = shift_reg;
        REG_FSC_B0: fsc_next[7:0] = shift_reg;
        REG_FSC_B1: fsc_next[15:8] = shift_reg;
        REG_FSC_B2: fsc_next[23:16] = shift_reg;
        REG_FSC_B3: fsc_next[31:24] = shift_reg;
        default: begin
        end
      endcase
    end
    // Being addressed wakes the core; the bus itself never sleeps
    if (addr_hit) begin
      std_next[BIT_CORE_SLEEP] = 1'b0;
    end
    // Without live control the decoder word follows the programmed one
    if (!burst_reg[BIT_REALTIME_SUBCARRIER_ENABLE]) begin
      rtc_next = fsc_reg;
    end else if (rtc_fsc_valid) begin
      rtc_next = rtc_fsc;
    end
    span_next = std_next[BIT_LUMA_GAIN] ? SPAN_92P5_IRE : SPAN_100_IRE;
    setup_next = std_next[BIT_LUMA_GAIN] ? SETUP_7P5_IRE : SETUP_NONE;
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      std_reg <= RST_STD_CTRL;
      burst_reg <= RST_BURST;
      fsc_reg <= RST_FSC;
      rtc_reg <= RST_FSC;
      span_reg <= SPAN_100_IRE;
      setup_reg <= SETUP_NONE;
    end else begin
      std_reg <= std_next;
      burst_reg <= burst_next;
      fsc_reg <= fsc_next;
      rtc_reg <= rtc_next;
      span_reg <= span_next;
      setup_reg <= setup_next;
    end
  end

  assign core_sleep = std_reg[BIT_CORE_SLEEP];
  assign dac_power_down = std_reg[BIT_DAC_PD];
  assign luma_gain_select = std_reg[BIT_LUMA_GAIN];
  assign luma_span_tenth_ire = span_reg;
  assign black_setup_tenth_ire = setup_reg;
  assign chroma_bandwidth_select = std_reg[BIT_CHROMA_BW];
  assign pal_mode = std_reg[BIT_PAL_MODE];
  assign line_length_select = std_reg[BIT_LINE_LEN];
  assign realtime_subcarrier_enable = burst_reg[BIT_REALTIME_SUBCARRIER_ENABLE];
  assign burst_amplitude = burst_reg[BURST_W-1:0];
  assign subcarrier_freq_word = fsc_reg;

  tve_gen_if gen_if ();

  assign gen_if.pixel_en = pixel_en;
  assign gen_if.run = ~std_reg[BIT_CORE_SLEEP];
  assign gen_if.pal_mode = std_reg[BIT_PAL_MODE];
  assign gen_if.line_length_select = std_reg[BIT_LINE_LEN];
  // Inversion is honoured only under live subcarrier control
  assign gen_if.invert_phase = std_reg[BIT_PAL_INV] & burst_reg[BIT_REALTIME_SUBCARRIER_ENABLE];
  assign gen_if.word = burst_reg[BIT_REALTIME_SUBCARRIER_ENABLE] ? rtc_reg : fsc_reg;

  tve_subcarrier_gen u_gen (
    .clk(clk),
    .rst(rst),
    .g(gen_if.gen)
  );

  assign subcarrier_phase = gen_if.phase;
  assign pal_switch = gen_if.pal_switch;
  assign line_start = gen_if.line_start;

  sequence s_std_write;
    wr_en && sub_reg == REG_STD_CTRL;
  endsequence
  sequence s_burst_write;
    wr_en && sub_reg == REG_BURST;
  endsequence

  a_sleep_wake: assert property (@(posedge clk) disable iff (rst)
    addr_hit |=> !core_sleep)
    else $error("core did not wake when addressed");
  a_dac_power: assert property (@(posedge clk) disable iff (rst)
    s_std_write |=> dac_power_down == $past(shift_reg[BIT_DAC_PD]))
    else $error("DAC power-down not taken from write");
  a_sleep_halts: assert property (@(posedge clk) disable iff (rst)
    core_sleep && pixel_en |=> $stable(subcarrier_phase) && !line_start)
    else $error("generator ran while asleep");
  a_invert_gate: assert property (@(posedge clk) disable iff (rst)
    !realtime_subcarrier_enable |-> !gen_if.invert_phase)
    else $error("PAL switch inverted without live control");
  a_luma_span: assert property (@(posedge clk) disable iff (rst)
    s_std_write ##1 1'b1 |-> (luma_span_tenth_ire == SPAN_92P5_IRE) == luma_gain_select
    && (black_setup_tenth_ire == SETUP_7P5_IRE) == luma_gain_select)
    else $error("luma span does not match gain select");
  a_chroma_bw: assert property (@(posedge clk) disable iff (rst)
    s_std_write |=> chroma_bandwidth_select == $past(shift_reg[BIT_CHROMA_BW]))
    else $error("chroma bandwidth not taken from write");
  a_burst_write: assert property (@(posedge clk) disable iff (rst)
    s_burst_write |=> burst_amplitude == $past(shift_reg[BURST_W-1:0]))
    else $error("burst amplitude not taken from write");
  a_fsc_msb: assert property (@(posedge clk) disable iff (rst)
    wr_en && sub_reg == REG_FSC_B3 |=> fsc_reg[31:24] == $past(shift_reg)
    && $stable(fsc_reg[23:0]))
    else $error("frequency top byte not placed in bits 31 to 24");
  a_rtc_word: assert property (@(posedge clk) disable iff (rst)
    !realtime_subcarrier_enable |-> gen_if.word == fsc_reg)
    else $error("generator word not programmed word without live control");
endmodule // tve_std_subcarrier

// [design/tve_pkg.sv]
// Constants, register map and types of the encoder standard and subcarrier block
package tve_pkg;
  localparam int FSC_W = 32;
  localparam int PHASE_W = 10;
  localparam int PIX_W = 10;
  localparam int IRE_W = 10;
  localparam int SETUP_W = 7;
  localparam int BURST_W = 7;

  // Register subaddresses
  localparam logic [7:0] REG_STD_CTRL = 8'h61;
  localparam logic [7:0] REG_BURST = 8'h62;
  localparam logic [7:0] REG_FSC_B0 = 8'h63;
  localparam logic [7:0] REG_FSC_B1 = 8'h64;
  localparam logic [7:0] REG_FSC_B2 = 8'h65;
  localparam logic [7:0] REG_FSC_B3 = 8'h66;

  // Standard control fields
  localparam int BIT_CORE_SLEEP = 7;
  localparam int BIT_DAC_PD = 6;
  localparam int BIT_PAL_INV = 5;
  localparam int BIT_LUMA_GAIN = 4;
  localparam int BIT_RESERVED = 3;
  localparam int BIT_CHROMA_BW = 2;
  localparam int BIT_PAL_MODE = 1;
  localparam int BIT_LINE_LEN = 0;
  // Burst register fields
  localparam int BIT_REALTIME_SUBCARRIER_ENABLE = 7;

  // Values after reset
  localparam logic [7:0] RST_STD_CTRL = 8'h04;
  localparam logic [7:0] RST_BURST = 8'h2f;
  localparam logic [FSC_W-1:0] RST_FSC = 32'h0000_0000;

  // Last pixel index of a line
  localparam logic [PIX_W-1:0] PIX_LAST_864 = 10'h35f;
  localparam logic [PIX_W-1:0] PIX_LAST_858 = 10'h359;

  // Luma span and black set-up in tenths of IRE
  localparam logic [IRE_W-1:0] SPAN_100_IRE = 10'h3e8;
  localparam logic [IRE_W-1:0] SPAN_92P5_IRE = 10'h39d;
  localparam logic [SETUP_W-1:0] SETUP_7P5_IRE = 7'h4b;
  localparam logic [SETUP_W-1:0] SETUP_NONE = 7'h00;

  // Control bus byte framing
  localparam logic [3:0] BYTE_BITS = 4'h8;

  typedef enum logic [3:0] {
    ST_IDLE, ST_ADDR, ST_ACK_ADDR, ST_SUB, ST_ACK_SUB,
    ST_WR, ST_ACK_WR, ST_RD, ST_ACK_RD
  } tve_bus_state_t;
endpackage

// [design/tve_gen_if.sv]
// Interface between the register bank and the subcarrier and line generator
interface tve_gen_if;
  logic pixel_en;
  logic run;
  logic pal_mode;
  logic line_length_select;
  logic invert_phase;
  logic [tve_pkg::FSC_W-1:0] word;
  logic [tve_pkg::PHASE_W-1:0] phase;
  logic pal_switch;
  logic line_start;

  modport ctrl (
    output pixel_en, run, pal_mode, line_length_select, invert_phase, word,
    input phase, pal_switch, line_start
  );
  modport gen (
    input pixel_en, run, pal_mode, line_length_select, invert_phase, word,
    output phase, pal_switch, line_start
  );
endinterface

// [design/tve_subcarrier_gen.sv]
// Subcarrier phase accumulator, pixel counter and PAL switch
module tve_subcarrier_gen (
  input wire logic clk,
  input wire logic rst,
  tve_gen_if.gen g
);
  import tve_pkg::*;

  logic [FSC_W-1:0] acc_reg, acc_next;
  logic [PIX_W-1:0] pix_reg, pix_next;
  logic alt_reg, alt_next;
  logic start_reg, start_next;
  logic [PIX_W-1:0] pix_last;

  assign pix_last = g.line_length_select ? PIX_LAST_858 : PIX_LAST_864;

  always_comb begin
    acc_next = acc_reg;
    pix_next = pix_reg;
    alt_next = alt_reg;
    start_next = 1'b0;
    if (g.pixel_en && g.run) begin
      acc_next = acc_reg + g.word;
      if (pix_reg >= pix_last) begin
        pix_next = '0;
        start_next = 1'b1;
        // NTSC clears the V phase, PAL flips it every line
        alt_next = g.pal_mode ? ~alt_reg : 1'b0;
      end else begin
        pix_next = pix_reg + 10'h001;
      end
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      acc_reg <= '0;
      pix_reg <= '0;
      alt_reg <= 1'b0;
      start_reg <= 1'b0;
    end else begin
      acc_reg <= acc_next;
      pix_reg <= pix_next;
      alt_reg <= alt_next;
      start_reg <= start_next;
    end
  end

  assign g.phase = acc_reg[FSC_W-1 -: PHASE_W];
  assign g.pal_switch = g.pal_mode & (alt_reg ^ g.invert_phase);
  assign g.line_start = start_reg;

  a_accum_step: assert property (@(posedge clk) disable iff (rst)
    (g.pixel_en && g.run) |=> acc_reg == $past(acc_reg) + $past(g.word))
    else $error("accumulator did not add the frequency word");
  a_line_wrap: assert property (@(posedge clk) disable iff (rst)
    (g.pixel_en && g.run && pix_reg == pix_last) |=> start_reg && pix_reg == 10'h000)
    else $error("line did not wrap at its last pixel");
  a_pal_alternate: assert property (@(posedge clk) disable iff (rst)
    (g.pixel_en && g.run && pix_reg == pix_last && g.pal_mode && $stable(g.pal_mode))
    |=> alt_reg != $past(alt_reg))
    else $error("PAL V phase did not alternate");
  a_ntsc_steady: assert property (@(posedge clk) disable iff (rst)
    (g.pixel_en && g.run && pix_reg >= pix_last && !g.pal_mode)
    |=> !alt_reg && (g.pal_mode || !g.pal_switch))
    else $error("NTSC switch not steady");
endmodule // tve_subcarrier_gen

// [testbench/tve_host_model.sv]
// Control bus host model: open-drain master with clk-based bit timing
module tve_host_model (
  input wire logic clk,
  input wire logic sda,
  output logic scl,
  output logic sda_pull
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    scl = 1'b1;
    sda_pull = 1'b0;
  end
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
  endtask
  // Data only moves while the clock line is low
  task automatic bit_io(input logic b, output logic r);
    sda_pull <= ~b;
    tick(3);
    scl <= 1'b1;
    tick(2);
    @(negedge clk);
    r = sda;
    tick(1);
    scl <= 1'b0;
    tick(3);
  endtask
  // Also serves as repeated start from a low clock line
  task automatic start();
    sda_pull <= 1'b0;
    tick(3);
    scl <= 1'b1;
    tick(3);
    sda_pull <= 1'b1;
    tick(3);
    scl <= 1'b0;
    tick(3);
  endtask
  task automatic stop();
    sda_pull <= 1'b1;
    tick(3);
    scl <= 1'b1;
    tick(3);
    sda_pull <= 1'b0;
    tick(3);
  endtask
  task automatic byte_io(input logic [7:0] d, input logic mack, output logic [7:0] q,
    output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      bit_io(d[i], r);
      q[i] = r;
    end
    bit_io(!mack, r);
    ack = !r;
  endtask
  task automatic write(input logic [6:0] a, input logic [7:0] sub, input logic [7:0] d[$],
    output logic ok);
    logic [7:0] q;
    logic k;
    start();
    byte_io({a, 1'b0}, 1'b0, q, ok);
    byte_io(sub, 1'b0, q, k);
    ok &= k;
    foreach (d[i]) begin
      byte_io(d[i], 1'b0, q, k);
      ok &= k;
    end
    stop();
  endtask
  // Single byte read, closed by a master NACK
  task automatic read(input logic [6:0] a, input logic [7:0] sub, output logic [7:0] q);
    logic k;
    start();
    byte_io({a, 1'b0}, 1'b0, q, k);
    byte_io(sub, 1'b0, q, k);
    start();
    byte_io({a, 1'b1}, 1'b0, q, k);
    byte_io(8'hff, 1'b0, q, k);
    stop();
  endtask
endmodule // tve_host_model

// [testbench/test_tv_encoder_standard_subcarrier_config.sv]
// Self-checking bench for the encoder standard and subcarrier register bank
module test_tv_encoder_standard_subcarrier_config;
  timeunit 1ns;
  timeprecision 1ps;
  import tve_pkg::*;
  localparam logic [6:0] DEV = 7'h2a;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic pixel_en = 1'b0;
  logic rtc_fsc_valid = 1'b0;
  logic [FSC_W-1:0] rtc_fsc = 32'h0;
  logic scl, sda_pull, sda_oe, sda_out, core_sleep, dac_power_down, luma_gain_select;
  logic chroma_bandwidth_select, pal_mode, line_length_select, realtime_subcarrier_enable;
  logic pal_switch, line_start;
  logic [IRE_W-1:0] luma_span_tenth_ire;
  logic [SETUP_W-1:0] black_setup_tenth_ire;
  logic [BURST_W-1:0] burst_amplitude;
  logic [FSC_W-1:0] subcarrier_freq_word;
  logic [PHASE_W-1:0] subcarrier_phase;
  int bad_count = 0;
  int tests_run = 0;
  logic [31:0] seed = 32'h47b49a12;
  logic [7:0] mreg [6];
  logic [31:0] acc_m, live_m;
  wire [31:0] word_m = {mreg[5], mreg[4], mreg[3], mreg[2]};
  // Pull-up line: whatever the slave puts on its data pin counts while enabled
  wire sda = (sda_oe ? sda_out : 1'b1) & !sda_pull;
  always #5 clk = ~clk;
  tve_std_subcarrier #(.DEV_ADDR(DEV)) tve_std_subcarrier_inst (
    .clk, .rst, .scl_in(scl), .sda_in(sda), .sda_out, .sda_oe, .pixel_en,
    .rtc_fsc_valid, .rtc_fsc, .core_sleep, .dac_power_down, .luma_gain_select,
    .luma_span_tenth_ire, .black_setup_tenth_ire, .chroma_bandwidth_select, .pal_mode,
    .line_length_select, .realtime_subcarrier_enable, .burst_amplitude,
    .subcarrier_freq_word, .subcarrier_phase, .pal_switch, .line_start
  );
  tve_host_model tve_host_model_inst (.clk, .sda, .scl, .sda_pull);
  function automatic logic [31:0] lfsr(input logic [31:0] x);
    return {x[30:0], 1'b0} ^ (x[31] ? 32'h04c11db7 : 32'h0);
  endfunction
  // Reference accumulator; register writes only happen with pixel_en low
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      acc_m <= 32'h0;
      live_m <= 32'h0;
    end else begin
      if (pixel_en && !mreg[0][7])
        acc_m <= acc_m + (mreg[1][7] ? live_m : word_m);
      if (!mreg[1][7])
        live_m <= word_m;
      else if (rtc_fsc_valid)
        live_m <= rtc_fsc;
    end
  end
  task automatic chk_out(input logic [31:0] g, input logic [31:0] e);
    tests_run++;
    if (g !== e) begin
      bad_count++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  task automatic chk_rd(input logic [7:0] g, input logic [7:0] e);
    tests_run++;
    if (g !== e) begin
      bad_count++;
      $display("[FAIL] t=%0t read=%h exp=%h", $time, g, e);
    end
  endtask
  task automatic test_done();
    if (bad_count == 0 && tests_run > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  task automatic check_outs();
    @(negedge clk);
    chk_out(core_sleep, mreg[0][7]);
    chk_out(dac_power_down, mreg[0][6]);
    chk_out(luma_gain_select, mreg[0][4]);
    chk_out(luma_span_tenth_ire, mreg[0][4] ? 925 : 1000);
    chk_out(black_setup_tenth_ire, mreg[0][4] ? 75 : 0);
    chk_out(chroma_bandwidth_select, mreg[0][2]);
    chk_out(pal_mode, mreg[0][1]);
    chk_out(line_length_select, mreg[0][0]);
    chk_out(realtime_subcarrier_enable, mreg[1][7]);
    chk_out(burst_amplitude, mreg[1][6:0]);
    chk_out(subcarrier_freq_word, word_m);
  endtask
  task automatic wr(input logic [7:0] sub, input logic [7:0] d[$]);
    logic ok;
    tve_host_model_inst.write(DEV, sub, d, ok);
    chk_out(ok, 1);
    mreg[0][7] = 1'b0;
    foreach (d[i])
      if (sub + i >= 8'h61 && sub + i <= 8'h66)
        mreg[sub + i - 8'h61] = d[i];
    check_outs();
  endtask
  task automatic rd(input logic [7:0] sub);
    logic [7:0] q;
    tve_host_model_inst.read(DEV, sub, q);
    mreg[0][7] = 1'b0;
    chk_rd(q, (sub >= 8'h61 && sub <= 8'h66) ? mreg[sub - 8'h61] : 8'h00);
  endtask
  // Random pixel enables, then compare the phase against the reference
  task automatic pix(input int n);
    repeat (n) begin
      @(posedge clk);
      seed = lfsr(seed);
      pixel_en <= seed[0];
    end
    @(posedge clk);
    pixel_en <= 1'b0;
    repeat (3) @(posedge clk);
    @(negedge clk);
    chk_out(subcarrier_phase, acc_m[31:22]);
  endtask
  task automatic wait_ls(output int k);
    k = 0;
    do begin
      @(negedge clk);
      k++;
    end while (line_start !== 1'b1 && k < 2000);
    if (line_start !== 1'b1) begin
      bad_count++;
      test_done();
    end
  endtask
  task automatic lines(input logic [7:0] std);
    int k;
    logic ps;
    wr(REG_STD_CTRL, {std});
    @(posedge clk);
    pixel_en <= 1'b1;
    wait_ls(k);
    repeat (2) @(negedge clk);
    ps = pal_switch;
    wait_ls(k);
    chk_out(k + 2, std[0] ? 858 : 864);
    repeat (2) @(negedge clk);
    chk_out(pal_switch, std[1] && !ps);
    @(posedge clk);
    pixel_en <= 1'b0;
  endtask
  initial begin
    logic [63:0] fw;
    logic [7:0] b8;
    logic [6:0] bst [4];
    logic ok, ps;
    bst = '{7'h3f, 7'h2d, 7'h43, 7'h2f};
    mreg = '{8'h04, 8'h2f, 8'h00, 8'h00, 8'h00, 8'h00};
    repeat (16) @(posedge clk);
    rst <= 1'b0;
    check_outs();
    chk_out(subcarrier_phase, 0);
    for (int s = 8'h60; s <= 8'h67; s++)
      rd(s[7:0]);
    repeat (6) begin
      seed = lfsr(seed);
      wr(REG_STD_CTRL, {seed[7:0] & 8'h77});
      rd(REG_STD_CTRL);
    end
    foreach (bst[i]) begin
      // Last value leaves live control off so the programmed word drives the phase
      b8 = {~i[0], bst[i]};
      wr(REG_BURST, {b8});
      rd(REG_BURST);
    end
    fw = ((64'd455 << 32) + 64'd1716) / 64'd3432;
    wr(REG_FSC_B0, {fw[7:0], fw[15:8], fw[23:16], fw[31:24]});
    wr(REG_FSC_B3, {8'h2a});
    wr(8'h60, {8'hff, 8'h00});
    wr(8'h67, {8'h55});
    for (int s = 8'h61; s <= 8'h67; s++)
      rd(s[7:0]);
    tve_host_model_inst.write(DEV + 7'h1, REG_BURST, {8'h00}, ok);
    chk_out(ok, 0);
    check_outs();
    pix(150);
    wr(REG_BURST, {8'haf});
    pix(40);
    @(posedge clk);
    seed = lfsr(seed);
    rtc_fsc <= seed;
    rtc_fsc_valid <= 1'b1;
    @(posedge clk);
    rtc_fsc_valid <= 1'b0;
    pix(150);
    wr(REG_BURST, {8'h2f});
    wr(REG_STD_CTRL, {8'hc4});
    pix(100);
    rd(REG_BURST);
    check_outs();
    lines(8'h04);
    lines(8'h03);
    lines(8'h02);
    pix(20);
    ps = pal_switch;
    wr(REG_BURST, {8'haf});
    chk_out(pal_switch, ps);
    wr(REG_STD_CTRL, {8'h22});
    chk_out(pal_switch, !ps);
    wr(REG_BURST, {8'h2f});
    chk_out(pal_switch, ps);
    test_done();
  end
endmodule // test_tv_encoder_standard_subcarrier_config
